// file: verilog/flash_host_ctrl.sv
// Host controller driving a parallel flash: security register, query mode and status polling
`timescale 1ns/100ps
module flash_host_ctrl
#(
    parameter int POR_CYCLES = flash_host_pkg::POR_CYC
)
(
    input  wire logic                              mclk_in,
    input  wire logic                              arst_n_in,
    input  wire logic                              cmd_valid_in,
    input  wire flash_host_pkg::cmd_t              cmd_in,
    output logic                                   cmd_ready_out,
    output logic                                   res_valid_out,
    output flash_host_pkg::result_t                res_out,
    output logic                                   flash_ready_out,
    output logic                                   ce_n_out,
    output logic                                   oe_n_out,
    output logic                                   we_n_out,
    output logic      [flash_host_pkg::ADDR_W-1:0] addr_out,
    output logic      [flash_host_pkg::DATA_W-1:0] dq_out,
    output logic                                   dq_oe_n_out,
    input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in,
    input  wire logic                              rdy_busy_in
);
    typedef enum logic [1:0] {S_IDLE, S_ISSUE, S_WAIT, S_GUARD} state_t;

    localparam int POR_W = $clog2(POR_CYCLES + 1);
    localparam logic [2:0] EXIT_IDX = 3'h5;

    function automatic flash_host_pkg::step_t mk(input flash_host_pkg::act_t a,
                                                 input logic [flash_host_pkg::ADDR_W-1:0] ad,
                                                 input logic [flash_host_pkg::DATA_W-1:0] d);
        flash_host_pkg::step_t s;
        s.act  = a;
        s.addr = ad;
        s.data = d;
        return s;
    endfunction

    function automatic flash_host_pkg::step_t step_of(input flash_host_pkg::cmd_t c,
                                                      input logic [2:0] i);
        flash_host_pkg::step_t s;
        logic [flash_host_pkg::DATA_W-1:0] code;
        s = mk(flash_host_pkg::ACT_END, flash_host_pkg::ADDR_ANY, '0);
        code = (c.op == flash_host_pkg::OP_SET_CFG) ? flash_host_pkg::D_SET_CFG :
               (c.op == flash_host_pkg::OP_PROG_SEC || c.op == flash_host_pkg::OP_LOCK_SEC)
               ? flash_host_pkg::D_SEC_PROG : flash_host_pkg::D_ID_ENTRY;
        case (c.op)
            flash_host_pkg::OP_READ:
                if (i == 3'h0)
                    s = mk(flash_host_pkg::ACT_RD, c.addr, '0);
            // query entry is one write, legal in read or identification mode
            flash_host_pkg::OP_CFI_ENTER:
                if (i == 3'h0)
                    s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_CFI, flash_host_pkg::D_CFI);
            flash_host_pkg::OP_ID_EXIT:
                if (i == 3'h0)
                    s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_ANY,
                           flash_host_pkg::D_ID_EXIT);
            default:
                case (i)
                    3'h0: s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_UNLOCK1,
                                 flash_host_pkg::D_UNLOCK1);
                    3'h1: s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_UNLOCK2,
                                 flash_host_pkg::D_UNLOCK2);
                    3'h2: s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_UNLOCK1, code);
                    3'h3:
                        // fourth cycle carries user address and data
                        if (c.op == flash_host_pkg::OP_PROG_SEC)
                            s = mk(flash_host_pkg::ACT_WR, c.addr, c.data);
                        // lock control bit cleared in the last cycle
                        else if (c.op == flash_host_pkg::OP_LOCK_SEC)
                            s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_LOCK_STATE,
                                   flash_host_pkg::D_SEC_LOCK);
                        else if (c.op == flash_host_pkg::OP_LOCK_STATE)
                            s = mk(flash_host_pkg::ACT_RD, flash_host_pkg::ADDR_LOCK_STATE, '0);
                        else if (c.op == flash_host_pkg::OP_READ_SEC)
                            s = mk(flash_host_pkg::ACT_RD, c.addr, '0);
                        else
                            s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_ANY,
                                   {14'h0000, c.data[1:0]});
                    3'h4:
                        if (c.op == flash_host_pkg::OP_PROG_SEC ||
                            c.op == flash_host_pkg::OP_LOCK_SEC)
                            s = mk(flash_host_pkg::ACT_POLL, c.addr, '0);
                        // leave identification mode before anything else
                        else if (c.op != flash_host_pkg::OP_SET_CFG)
                            s = mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_ANY,
                                   flash_host_pkg::D_ID_EXIT);
                    default: s = mk(flash_host_pkg::ACT_END, flash_host_pkg::ADDR_ANY, '0);
                endcase
        endcase
        return s;
    endfunction

    state_t                   state_q;
    state_t                   state_d;
    flash_host_pkg::cmd_t     cmd_q;
    logic [2:0]               idx_q;
    logic                     exit_q;
    logic                     have_prev_q;
    logic                     prev_tog_q;
    logic [1:0]               recheck_q;
    logic [3:0]               guard_q;
    logic [POR_W-1:0]         por_cnt_q;
    logic [2:0]               rdy_sync_q;
    flash_host_pkg::result_t  res_d;
    logic                     eng_done;
    logic [flash_host_pkg::DATA_W-1:0] eng_rdata;

    // programming only after the power-on delay
    wire por_done = (por_cnt_q == POR_W'(POR_CYCLES));
    wire accept   = cmd_ready_out && cmd_valid_in;

    // the factory half may never be written; only user words qualify
    wire [flash_host_pkg::ADDR_W-1:0] sec_off = cmd_in.addr - flash_host_pkg::SEC_BASE;
    wire in_user = (cmd_in.addr >= flash_host_pkg::SEC_BASE) &&
                   (sec_off >= 20'(flash_host_pkg::SEC_HALF_WORDS)) &&
                   (sec_off < 20'(2 * flash_host_pkg::SEC_HALF_WORDS));
    wire refuse  = (cmd_in.op == flash_host_pkg::OP_PROG_SEC) && !in_user;

    wire flash_host_pkg::step_t cur_step = (exit_q && idx_q == EXIT_IDX)
        ? mk(flash_host_pkg::ACT_WR, flash_host_pkg::ADDR_ANY, flash_host_pkg::D_ID_EXIT)
        : step_of(cmd_q, idx_q);
    wire eng_start  = (state_q == S_ISSUE) && (cur_step.act != flash_host_pkg::ACT_END);
    wire eng_write  = (cur_step.act == flash_host_pkg::ACT_WR);
    wire is_poll    = (cur_step.act == flash_host_pkg::ACT_POLL);
    // toggling stopped when two successive reads agree
    wire tog_stable = have_prev_q && (eng_rdata[flash_host_pkg::TOGGLE_BIT] == prev_tog_q);
    wire fault_seen = eng_rdata[flash_host_pkg::FAILURE_BIT] |
                      eng_rdata[flash_host_pkg::SUPPLY_FAULT_BIT];
    // after a fault two more reads confirm the toggle state
    wire poll_fail  = fault_seen && !tog_stable && (recheck_q == 2'h2);

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            S_IDLE:  if (accept) state_d = refuse ? S_GUARD : S_ISSUE;
            S_ISSUE: state_d = eng_start ? S_WAIT : S_GUARD;
            S_WAIT:  if (eng_done) state_d = S_ISSUE;
            S_GUARD: if (guard_q == 4'(flash_host_pkg::GUARD_CYC)) state_d = S_IDLE;
        endcase
    end

    always_comb
    begin
        res_d = res_out;
        if (accept)
        begin
            res_d         = '0;
            res_d.refused = refuse;
        end
        else if (state_q == S_WAIT && eng_done && !eng_write)
        begin
            if (!is_poll || tog_stable)
                res_d.data = eng_rdata;
            if (cmd_q.op == flash_host_pkg::OP_LOCK_STATE && !is_poll)
                res_d.locked = !eng_rdata[flash_host_pkg::LOCK_CONTROL_BIT];
            // a fault counts only once toggling is confirmed ongoing
            if (is_poll && poll_fail)
            begin
                res_d.fail         = eng_rdata[flash_host_pkg::FAILURE_BIT];
                res_d.supply_fault = eng_rdata[flash_host_pkg::SUPPLY_FAULT_BIT];
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q   <= S_IDLE;
            cmd_q     <= '0;
            guard_q   <= 4'h0;
            por_cnt_q <= '0;
            res_out   <= '0;
        end
        else
        begin
            state_q   <= state_d;
            res_out   <= res_d;
            por_cnt_q <= por_done ? por_cnt_q : por_cnt_q + POR_W'(1);
            guard_q   <= (state_q == S_GUARD) ? guard_q + 4'h1 : 4'h0;
            if (accept)
                cmd_q <= cmd_in;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            idx_q       <= 3'h0;
            exit_q      <= 1'b0;
            have_prev_q <= 1'b0;
            prev_tog_q  <= 1'b0;
            recheck_q   <= 2'h0;
        end
        else if (accept)
        begin
            idx_q       <= 3'h0;
            exit_q      <= 1'b0;
            have_prev_q <= 1'b0;
            recheck_q   <= 2'h0;
        end
        else if (state_q == S_WAIT && eng_done)
        begin
            if (!is_poll || tog_stable)
                idx_q <= idx_q + 3'h1;
            else if (poll_fail)
            begin
                // A fault leaves the device in status mode, so send the exit write
                idx_q  <= EXIT_IDX;
                exit_q <= 1'b1;
            end
            else
            begin
                have_prev_q <= 1'b1;
                prev_tog_q  <= eng_rdata[flash_host_pkg::TOGGLE_BIT];
                if (fault_seen)
                    recheck_q <= recheck_q + 2'h1;
            end
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            cmd_ready_out   <= 1'b0;
            res_valid_out   <= 1'b0;
            rdy_sync_q      <= 3'h0;
            flash_ready_out <= 1'b0;
        end
        else
        begin
            cmd_ready_out <= (state_d == S_IDLE) && por_done && !accept;
            res_valid_out <= (state_q == S_ISSUE) && !eng_start;
            rdy_sync_q    <= {rdy_sync_q[1:0], rdy_busy_in};
            // open-drain line reads high only when every device has released it
            if (rdy_sync_q[1] == rdy_sync_q[2])
                flash_ready_out <= rdy_sync_q[2];
        end
    end

    flash_bus_cycle i_flash_bus_cycle
    (
        .mclk_in     (mclk_in),
        .arst_n_in   (arst_n_in),
        .start_in    (eng_start),
        .write_in    (eng_write),
        .addr_in     (cur_step.addr),
        .data_in     (cur_step.data),
        .done_out    (eng_done),
        .rdata_out   (eng_rdata),
        .ce_n_out    (ce_n_out),
        .oe_n_out    (oe_n_out),
        .we_n_out    (we_n_out),
        .addr_out    (addr_out),
        .dq_out      (dq_out),
        .dq_oe_n_out (dq_oe_n_out),
        .dq_in       (dq_in)
    );
endmodule

// file: verilog/flash_host_pkg.sv
// Constants and types shared by the flash host controller and its bus cycle engine
package flash_host_pkg;

    localparam int CLK_MHZ       = 50;
    localparam int CLK_PERIOD_NS = 20;

    // Bus timing, least times rounded up to whole cycles
    localparam int T_WE_PULSE_NS = 40;
    localparam int WE_PULSE_CYC  = (T_WE_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_ACCESS_NS   = 70;
    localparam int ACCESS_CYC    = (T_ACCESS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int SYNC_CYC      = 3;
    localparam int T_GUARD_NS    = 100;
    localparam int GUARD_CYC     = (T_GUARD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int T_POR_MS      = 10;
    localparam int POR_CYC       = T_POR_MS * 1000 * CLK_MHZ;

    localparam int ADDR_W = 20;
    localparam int DATA_W = 16;

    // Command addresses
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK1    = 20'h00555;
    localparam logic [ADDR_W-1:0] ADDR_UNLOCK2    = 20'h00aaa;
    localparam logic [ADDR_W-1:0] ADDR_LOCK_STATE = 20'h00080;
    localparam logic [ADDR_W-1:0] ADDR_CFI        = 20'h00055;
    localparam logic [ADDR_W-1:0] ADDR_ANY        = 20'h00000;
    localparam logic [ADDR_W-1:0] SEC_BASE        = 20'h00081;
    localparam int                SEC_HALF_WORDS  = 4;

    // Command data
    localparam logic [DATA_W-1:0] D_UNLOCK1  = 16'h00aa;
    localparam logic [DATA_W-1:0] D_UNLOCK2  = 16'h0055;
    localparam logic [DATA_W-1:0] D_ID_ENTRY = 16'h0090;
    localparam logic [DATA_W-1:0] D_ID_EXIT  = 16'h00f0;
    localparam logic [DATA_W-1:0] D_SEC_PROG = 16'h00c0;
    localparam logic [DATA_W-1:0] D_SEC_LOCK = 16'h0000;
    localparam logic [DATA_W-1:0] D_SET_CFG  = 16'h00d0;
    localparam logic [DATA_W-1:0] D_CFI      = 16'h0098;

    // Status bit positions
    localparam int POLLING_BIT       = 7;
    localparam int TOGGLE_BIT        = 6;
    localparam int FAILURE_BIT       = 5;
    localparam int SUPPLY_FAULT_BIT  = 3;
    localparam int ERASE_TOGGLE_BIT  = 2;
    localparam int LOCK_CONTROL_BIT  = 1;

    typedef enum logic [2:0] {
        OP_READ, OP_PROG_SEC, OP_LOCK_SEC, OP_LOCK_STATE,
        OP_READ_SEC, OP_CFI_ENTER, OP_ID_EXIT, OP_SET_CFG
    } op_t;

    typedef enum logic [1:0] {ACT_WR, ACT_RD, ACT_POLL, ACT_END} act_t;

    typedef struct packed {
        op_t               op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } cmd_t;

    typedef struct packed {
        act_t              act;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } step_t;

    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic              locked;
        logic              fail;
        logic              supply_fault;
        logic              refused;
    } result_t;

endpackage

// file: verilog/flash_bus_cycle.sv
// One asynchronous flash bus cycle: a write strobe or a read with synchronised capture
`timescale 1ns/100ps
module flash_bus_cycle
(
    input  wire logic                              mclk_in,
    input  wire logic                              arst_n_in,
    input  wire logic                              start_in,
    input  wire logic                              write_in,
    input  wire logic [flash_host_pkg::ADDR_W-1:0] addr_in,
    input  wire logic [flash_host_pkg::DATA_W-1:0] data_in,
    output logic                                   done_out,
    output logic      [flash_host_pkg::DATA_W-1:0] rdata_out,
    output logic                                   ce_n_out,
    output logic                                   oe_n_out,
    output logic                                   we_n_out,
    output logic      [flash_host_pkg::ADDR_W-1:0] addr_out,
    output logic      [flash_host_pkg::DATA_W-1:0] dq_out,
    output logic                                   dq_oe_n_out,
    input  wire logic [flash_host_pkg::DATA_W-1:0] dq_in
);
    typedef enum logic [1:0] {E_IDLE, E_SETUP, E_PULSE, E_HOLD} eng_state_t;

    localparam logic [7:0] WR_CNT = 8'(flash_host_pkg::WE_PULSE_CYC - 1);
    localparam logic [7:0] RD_CNT = 8'(flash_host_pkg::ACCESS_CYC + flash_host_pkg::SYNC_CYC - 1);

    eng_state_t                      state_q;
    logic                            write_q;
    logic [7:0]                      cnt_q;
    logic [flash_host_pkg::DATA_W-1:0] dq_s1_q;
    logic [flash_host_pkg::DATA_W-1:0] dq_s2_q;
    logic [flash_host_pkg::DATA_W-1:0] dq_s3_q;

    // A read ends only once the last two sync stages agree on the bus value
    wire pulse_end = (cnt_q == 8'h00) && (write_q || (dq_s2_q == dq_s3_q));

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            dq_s1_q <= '0;
            dq_s2_q <= '0;
            dq_s3_q <= '0;
        end
        else
        begin
            dq_s1_q <= dq_in;
            dq_s2_q <= dq_s1_q;
            dq_s3_q <= dq_s2_q;
        end
    end

    always_ff @(posedge mclk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            state_q     <= E_IDLE;
            write_q     <= 1'b0;
            cnt_q       <= 8'h00;
            done_out    <= 1'b0;
            rdata_out   <= '0;
            ce_n_out    <= 1'b1;
            oe_n_out    <= 1'b1;
            we_n_out    <= 1'b1;
            addr_out    <= '0;
            dq_out      <= '0;
            dq_oe_n_out <= 1'b1;
        end
        else
        begin
            done_out <= 1'b0;
            unique case (state_q)
                E_IDLE:
                    if (start_in)
                    begin
                        write_q     <= write_in;
                        addr_out    <= addr_in;
                        dq_out      <= data_in;
                        dq_oe_n_out <= !write_in;
                        ce_n_out    <= 1'b0;
                        state_q     <= E_SETUP;
                    end
                E_SETUP:
                begin
                    // strobe only with chip selected and output enable high
                    we_n_out <= !write_q;
                    oe_n_out <= write_q;
                    cnt_q    <= write_q ? WR_CNT : RD_CNT;
                    state_q  <= E_PULSE;
                end
                E_PULSE:
                    if (!pulse_end)
                        cnt_q <= (cnt_q == 8'h00) ? cnt_q : cnt_q - 8'h01;
                    else
                    begin
                        if (!write_q)
                            rdata_out <= dq_s3_q;
                        we_n_out <= 1'b1;
                        oe_n_out <= 1'b1;
                        state_q  <= E_HOLD;
                    end
                E_HOLD:
                begin
                    ce_n_out    <= 1'b1;
                    dq_oe_n_out <= 1'b1;
                    done_out    <= 1'b1;
                    state_q     <= E_IDLE;
                end
            endcase
        end
    end
endmodule

// file: bench/flash_host_ctrl_monitor.sv
// Port checker for the flash host controller, bound to its top module
`timescale 1ns/100ps
module flash_host_ctrl_monitor #(parameter int POR_CYCLES = 20)
(
    input wire logic                 mclk_in,
    input wire logic                 arst_n_in,
    input wire logic                 cmd_valid_in,
    input wire flash_host_pkg::cmd_t cmd_in,
    input wire logic                 cmd_ready_out,
    input wire logic                 res_valid_out,
    input wire logic                 ce_n_out,
    input wire logic                 oe_n_out,
    input wire logic                 we_n_out,
    input wire logic                 dq_oe_n_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!arst_n_in);
    int  por_q;
    wire accept   = cmd_valid_in && cmd_ready_out;
    wire bad_prog = accept && cmd_in.op == flash_host_pkg::OP_PROG_SEC
        && (cmd_in.addr < flash_host_pkg::SEC_BASE + 4 || cmd_in.addr > flash_host_pkg::SEC_BASE + 7);
    always_ff @(posedge mclk_in or negedge arst_n_in)
        if (!arst_n_in)
            por_q <= 0;
        else if (por_q < POR_CYCLES)
            por_q <= por_q + 1;
    sequence s_we_pulse;
        !we_n_out [*2] ##1 we_n_out;
    endsequence
    AST_POR_HOLD: assert property ((por_q < POR_CYCLES) |-> !cmd_ready_out)
        else $error("command port open during power-on delay");
    AST_WE_CLEAN: assert property (!we_n_out |-> oe_n_out && !ce_n_out)
        else $error("write strobe without chip select or with output enable");
    AST_WE_PULSE: assert property ($fell(we_n_out) |-> s_we_pulse)
        else $error("write strobe not two cycles long");
    AST_NO_CLASH: assert property (!oe_n_out |-> dq_oe_n_out)
        else $error("host drives data during a read");
    AST_GUARD: assert property (res_valid_out |=> !cmd_ready_out [*5])
        else $error("guard interval cut short");
    AST_RES_PULSE: assert property (res_valid_out |=> !res_valid_out)
        else $error("result valid longer than one cycle");
    AST_REFUSE: assert property (bad_prog |=> ce_n_out [*6])
        else $error("factory half program reached the bus");
    AST_OE_AFTER_CE: assert property ($fell(oe_n_out) |-> !$past(ce_n_out))
        else $error("output enable before chip select");
endmodule
bind flash_host_ctrl flash_host_ctrl_monitor #(.POR_CYCLES(POR_CYCLES)) i_flash_host_ctrl_monitor (
    .mclk_in(mclk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
    .cmd_ready_out(cmd_ready_out), .res_valid_out(res_valid_out), .ce_n_out(ce_n_out),
    .oe_n_out(oe_n_out), .we_n_out(we_n_out), .dq_oe_n_out(dq_oe_n_out));

// file: bench/flash_dev_model.sv
// Behavioural parallel flash: security register, query mode and status reads
`timescale 1ns/100ps
module flash_dev_model #(parameter int BUSY_NS = 2000)
(
    input  wire logic        ce_n_in,
    input  wire logic        oe_n_in,
    input  wire logic        we_n_in,
    input  wire logic [19:0] addr_in,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out,
    output logic             busy_out
);
    logic [15:0] sec_q [8];
    logic [15:0] last_q;
    logic [19:0] prog_a_q;
    logic [7:0]  mode_q;
    logic [1:0]  step_q, cfg_q;
    logic        id_q, cfi_q, lock_q, tog_q, fail_q;
    wire  [19:0] idx = addr_in - flash_host_pkg::SEC_BASE;
    wire  [7:0]  wd  = dq_in[7:0];
    wire  [11:0] wa  = addr_in[11:0];
    wire         ul  = step_q[0] ? (wa == 12'haaa && wd == 8'h55) : (wa == 12'h555 && wd == 8'haa);
    wire  [15:0] rd_val =
        fail_q ? {8'h00, 1'b0, tog_q, 1'b1, 5'h00} :
        (busy_out && addr_in == prog_a_q) ? {8'h00, !cfg_q[0] && !sec_q[idx[2:0]][7], tog_q, 6'h00} :
        cfi_q ? 16'h0051 :
        (id_q && addr_in == 20'h00080) ? {14'h0000, !lock_q, 1'b0} :
        (id_q && idx < 20'h8) ? sec_q[idx[2:0]] : addr_in[15:0] ^ 16'h5a5a;
    // Released lines show the inverse of the last value, not a held copy
    assign dq_out = (!ce_n_in && !oe_n_in) ? rd_val : ~last_q;
    // Only a real read end counts; the reset edge of the strobe must not toggle
    always @(posedge oe_n_in)
        if (ce_n_in === 1'b0)
        begin
            last_q <= rd_val;
            tog_q  <= tog_q ^ (busy_out | fail_q);
        end
    // write decode on a clean strobe
    always @(posedge we_n_in)
        if (!ce_n_in && oe_n_in && !busy_out)
        begin
            if (wd == 8'hf0)
                {id_q, cfi_q, fail_q, step_q} = 5'h0;
            else if (wa == 12'h055 && wd == 8'h98)
                cfi_q = 1'b1;
            else if (step_q < 2'h2)
                step_q = ul ? step_q + 2'h1 : 2'h0;
            else if (step_q == 2'h2)
            begin
                id_q   = id_q | (wd == 8'h90);
                mode_q = wd;
                step_q = (wd == 8'hc0 || wd == 8'hd0) ? 2'h3 : 2'h0;
            end
            else
            begin
                step_q = 2'h0;
                // setting, lock bit, user half only, busy low
                if (mode_q == 8'hd0)
                    cfg_q = dq_in[1:0];
                else if (addr_in == 20'h00080)
                    lock_q = lock_q | ~dq_in[1];
                else if (!lock_q && idx >= 20'h4 && idx < 20'h8)
                begin
                    {sec_q[idx[2:0]], prog_a_q} = {dq_in, addr_in};
                    busy_out = 1'b1;
                    busy_out <= #(BUSY_NS) 1'b0;
                end
                // program into a locked user half falls into status mode
                else if (idx >= 20'h4 && idx < 20'h8)
                    fail_q = 1'b1;
            end
        end
    // factory words are arbitrary values; user half erased
    initial
    begin
        for (int i = 0; i < 8; i++)
            sec_q[i] = (i < 4) ? (16'hf000 | 16'(i)) : 16'hffff;
        {id_q, cfi_q, lock_q, tog_q, fail_q, busy_out, step_q, cfg_q, last_q, prog_a_q, mode_q} = 54'h0;
    end
endmodule

// file: bench/test_flash_host_ctrl.sv
// Self-checking bench: host controller against a behavioural flash
`timescale 1ns/100ps
module test_flash_host_ctrl;
    typedef struct {logic [2:0] op; logic [19:0] a; logic [15:0] d, exp; int kind;} stim_t;
    localparam logic [19:0] SB = flash_host_pkg::SEC_BASE;
    logic                    mclk_in, arst_n_in, cmd_valid_in, cmd_ready_out, res_valid_out;
    logic                    flash_ready_out, ce_n_out, oe_n_out, we_n_out, dq_oe_n_out, busy, busy_seen;
    logic [19:0]             addr_out;
    logic [15:0]             dq_out, dev_dq;
    flash_host_pkg::cmd_t    cmd_in;
    flash_host_pkg::result_t res_out;
    int                      errors = 0, n_tests = 0;
    wire  [15:0]             dq_bus = dq_oe_n_out ? dev_dq : dq_out;
    // Kind: 0 data, 1 locked, 2 refused, 3 busy seen with fail and supply fault flags, 4 none
    stim_t tbl [17] = '{
        '{3'h4, SB, 16'h0, 16'hf000, 0},
        '{3'h1, SB + 20'h1, 16'h1234, 16'h1, 2},
        '{3'h3, 20'h80, 16'h0, 16'h0, 1},
        '{3'h1, SB + 20'h4, 16'h1234, 16'h1, 3},
        '{3'h4, SB + 20'h4, 16'h0, 16'h1234, 0},
        '{3'h7, 20'h0, 16'h1, 16'h0, 4},
        '{3'h1, SB + 20'h7, 16'h0a5c, 16'h1, 3},
        '{3'h4, SB + 20'h7, 16'h0, 16'h0a5c, 0},
        '{3'h2, 20'h80, 16'hfffd, 16'h0, 4},
        '{3'h3, 20'h80, 16'h0, 16'h1, 1},
        '{3'h1, SB + 20'h5, 16'h5555, 16'h2, 3},
        '{3'h4, SB + 20'h5, 16'h0, 16'hffff, 0},
        '{3'h5, 20'h55, 16'h98, 16'h0, 4},
        '{3'h0, 20'h10, 16'h0, 16'h0051, 0},
        '{3'h0, 20'h11, 16'h0, 16'h0051, 0},
        '{3'h6, 20'h0, 16'hf0, 16'h0, 4},
        '{3'h0, 20'h10, 16'h0, 16'h5a4a, 0}};
    // ready line is open drain with a pull-up; the flash only pulls it low
    flash_host_ctrl #(.POR_CYCLES(20)) i_flash_host_ctrl (
        .mclk_in(mclk_in), .arst_n_in(arst_n_in), .cmd_valid_in(cmd_valid_in), .cmd_in(cmd_in),
        .cmd_ready_out(cmd_ready_out), .res_valid_out(res_valid_out), .res_out(res_out),
        .flash_ready_out(flash_ready_out), .ce_n_out(ce_n_out), .oe_n_out(oe_n_out),
        .we_n_out(we_n_out), .addr_out(addr_out), .dq_out(dq_out), .dq_oe_n_out(dq_oe_n_out),
        .dq_in(dq_bus), .rdy_busy_in(~busy));
    flash_dev_model i_flash_dev_model (.ce_n_in(ce_n_out), .oe_n_in(oe_n_out), .we_n_in(we_n_out),
        .addr_in(addr_out), .dq_in(dq_bus), .dq_out(dev_dq), .busy_out(busy));
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic summarize();
        if (errors == 0 && n_tests > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Wait for ready, offer a command for one cycle, then wait for its result unless refused
    task automatic run(input stim_t t);
        int n;
        n = 0;
        while (cmd_ready_out !== 1'b1 && n < 500)
            @(posedge mclk_in) #1 n++;
        cmd_valid_in = 1'b1;
        cmd_in = '{flash_host_pkg::op_t'(t.op), t.a, t.d};
        @(posedge mclk_in) #1 cmd_valid_in = 1'b0;
        busy_seen = 1'b0;
        while (t.kind != 2 && res_valid_out !== 1'b1 && n < 4000)
        begin
            busy_seen = busy_seen | (flash_ready_out === 1'b0);
            @(posedge mclk_in) #1 n++;
        end
        if (t.kind == 2)
            @(posedge mclk_in) #1 chk("res_valid", 16'h0, {15'h0, res_valid_out});
        else
            chk("res_valid", 16'h1, {15'h0, res_valid_out});
        case (t.kind)
            0: chk("data", t.exp, res_out.data);
            1: chk("locked", t.exp, {15'h0, res_out.locked});
            2: chk("refused", t.exp, {15'h0, res_out.refused});
            3: chk("busy_fail", t.exp, {13'h0, res_out.supply_fault, res_out.fail, busy_seen});
            default: ;
        endcase
    endtask
    initial
    begin
        mclk_in = 1'b0;
        forever #10 mclk_in = ~mclk_in;
    end
    initial
    begin
        #400000 errors++;
        summarize();
    end
    initial
    begin
        arst_n_in = 1'b0;
        cmd_valid_in = 1'b0;
        cmd_in = '0;
        repeat (8) @(posedge mclk_in);
        #1 arst_n_in = 1'b1;
        repeat (10) @(posedge mclk_in);
        #1 chk("ready_early", 16'h0, {15'h0, cmd_ready_out});
        foreach (tbl[i])
            run(tbl[i]);
        summarize();
    end
endmodule
